/* logic/serial_unit_defines.svh */
// constants of the serial unit control and status words
`ifndef SERIAL_UNIT_DEFINES_SVH
`define SERIAL_UNIT_DEFINES_SVH

// ****************************************
// word offsets in shared data memory
// ****************************************
`define CTRL_OFS 2'h0
`define STAT_OFS 2'h1
`define SYNADDR_OFS 2'h2

// ****************************************
// control word fields
// ****************************************
`define CTRL_RUN_LSB 0
`define CTRL_TMO_LSB 4
`define CTRL_CNT_LSB 8
`define CTRL_RESET 16'h0000
`define RUN_DIGIT 4'h1
`define MAX_UNITS 6'h20

// ****************************************
// status word fields
// ****************************************
`define STAT_CODE_LSB 0
`define STAT_STOP_LSB 8
`define STAT_FLAG_LSB 12
`define STAT_RESET 16'h0000
`define SYNADDR_RESET 16'h0000
`define CODE_WDT 8'h01
`define CODE_SYNTAX 8'h02
`define CODE_DM_ALLOC 8'h15
`define ERR_FLAG_DIGIT 4'h8
`define STOP_DIGIT_RUN 4'h1
`define STOP_DIGIT_HALT 4'h0

// ****************************************
// timing
// ****************************************
`define CLK_MHZ 100
`define TMO_UNIT_MS 500
`define TMO_UNIT_CYC (`TMO_UNIT_MS * 1000 * `CLK_MHZ)
`define BLINK_HALF_MS 250
`define BLINK_HALF_CYC (`BLINK_HALF_MS * 1000 * `CLK_MHZ)

`endif

/* logic/serial_unit_pkg.sv */
// types of the serial unit control and status words
package serial_unit_pkg;

  // ****************************************
  // error events
  // ****************************************
  typedef struct packed {
    logic wdt;
    logic syntax;
    logic dm_alloc;
  } err_evt_t;

  // ****************************************
  // control word layout
  // ****************************************
  typedef struct packed {
    logic [7:0] count_bcd;
    logic [3:0] tmo_bcd;
    logic [3:0] run;
  } ctrl_word_t;

  typedef enum logic [1:0] {
    POLL_IDLE,
    POLL_ISSUE,
    POLL_WAIT
  } poll_state_t;

endpackage

/* logic/interval_timer.sv */
// one-shot down counter with a registered expiry pulse
`timescale 1ns/10ps
`default_nettype none

module interval_timer (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic abort,
  input wire logic [31:0] load,
  output logic busy,
  output logic expired
);

  logic [31:0] cnt_r;
  logic busy_r;
  logic expired_r;

  // ****************************************
  // counter
  // ****************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= 32'h0;
      busy_r <= 1'b0;
      expired_r <= 1'b0;
    end else begin
      expired_r <= 1'b0;
      if (start) begin
        cnt_r <= load;
        busy_r <= 1'b1;
      end else if (abort) begin
        busy_r <= 1'b0;
      end else if (busy_r) begin
        // zero load still costs one cycle
        if (cnt_r <= 32'h1) begin
          busy_r <= 1'b0;
          expired_r <= 1'b1;
        end else begin
          cnt_r <= cnt_r - 32'h1;
        end
      end
    end
  end

  assign busy = busy_r;
  assign expired = expired_r;

endmodule // interval_timer

`default_nettype wire

/* logic/serial_unit_control_status.sv */
// control and status words of the serial polling unit
// Operation
// - run digit 1 starts polling and exchange
// - latched fatal error blocks polling despite run
// - run digit 0 means no component traffic
// - response timeout is (digit+1) times 500 ms
// - bcd component count 00 to 32
// - zero component count suppresses all traffic
// - error flag set: low byte holds code
// - watchdog: code 01, halt, led steady
// - syntax: record address, code 02, halt, blink
// - missing memory address: code 15, halt, steady
// - any error halts, stop digit cleared
// - top status digit 8 on error
// - no error: last unit to answer ok, run digit
// - syntax address word keeps first error
`timescale 1ns/10ps
`default_nettype none
`include "serial_unit_defines.svh"

module serial_unit_control_status #(
  parameter logic [31:0] TMO_UNIT_CYC = 32'(`TMO_UNIT_CYC),
  parameter logic [31:0] BLINK_HALF_CYC = 32'(`BLINK_HALF_CYC)
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  input wire logic [1:0] cpu_addr,
  input wire logic [15:0] cpu_wdata,
  output logic [15:0] cpu_rdata,
  input wire serial_unit_pkg::err_evt_t err_evt,
  input wire logic [15:0] syntax_addr_bcd,
  input wire logic resp_valid,
  input wire logic resp_ok,
  output logic poll_req,
  output logic [4:0] poll_unit,
  output logic running,
  output logic err_led
);

  serial_unit_pkg::ctrl_word_t ctrl_r;
  logic [15:0] stat_r;
  logic [15:0] stat_nxt;
  logic [15:0] synaddr_r;
  logic [15:0] cpu_rdata_r;
  logic [7:0] code_r;
  logic fatal_r;
  logic nonfatal_r;
  logic [3:0] run_prev_r;
  serial_unit_pkg::poll_state_t state_r;
  logic [4:0] idx_r;
  logic [7:0] last_unit_r;
  logic poll_req_r;
  logic [4:0] poll_unit_r;
  logic running_r;
  logic err_led_r;
  logic blink_r;
  logic [5:0] units;
  logic [6:0] units_raw;
  logic [7:0] idx_bcd;
  logic go;
  logic any_err;
  logic [31:0] tmo_load;
  logic tmo_start;
  logic tmo_abort;
  logic tmo_exp;
  logic blink_busy;
  logic blink_exp;
  logic [4:0] idx_next;

  // ****************************************
  // decoded control settings
  // ****************************************
  // counts above 32 are clamped rather than wrapping
  // seven bits, since two bcd digits reach 99
  always_comb begin
    units_raw = 7'(ctrl_r.count_bcd[7:4]) * 7'd10 + 7'(ctrl_r.count_bcd[3:0]);
    units = units_raw[5:0];
    if (units_raw > 7'(`MAX_UNITS)) begin
      units = `MAX_UNITS;
    end
  end

  assign any_err = fatal_r | nonfatal_r;
  assign go = (ctrl_r.run == `RUN_DIGIT)
    && !fatal_r
    && !nonfatal_r
    && (units != 6'h0);
  assign tmo_load = (32'(ctrl_r.tmo_bcd) + 32'h1) * TMO_UNIT_CYC;
  assign tmo_start = (state_r == serial_unit_pkg::POLL_ISSUE);
  assign tmo_abort = (state_r == serial_unit_pkg::POLL_WAIT) && (!go || resp_valid);
  assign idx_next = (6'(idx_r) + 6'h1 >= units) ? 5'h0 : idx_r + 5'h1;

  // ****************************************
  // word port
  // ****************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r <= `CTRL_RESET;
    end else if (cpu_wr && cpu_addr == `CTRL_OFS) begin
      ctrl_r <= cpu_wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cpu_rdata_r <= 16'h0000;
    end else if (cpu_rd) begin
      case (cpu_addr)
        `CTRL_OFS: cpu_rdata_r <= ctrl_r;
        `STAT_OFS: cpu_rdata_r <= stat_r;
        `SYNADDR_OFS: cpu_rdata_r <= synaddr_r;
        default: cpu_rdata_r <= 16'h0000;
      endcase
    end
  end

  // ****************************************
  // error latches
  // ****************************************
  // watchdog is cleared only by reset; the others by a run to stop step
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      run_prev_r <= 4'h0;
      fatal_r <= 1'b0;
      nonfatal_r <= 1'b0;
      code_r <= 8'h00;
    end else begin
      run_prev_r <= ctrl_r.run;
      if (err_evt.wdt) begin
        fatal_r <= 1'b1;
        nonfatal_r <= 1'b0;
        code_r <= `CODE_WDT;
      end else if (err_evt.dm_alloc && code_r != `CODE_WDT) begin
        fatal_r <= 1'b1;
        nonfatal_r <= 1'b0;
        code_r <= `CODE_DM_ALLOC;
      end else if (err_evt.syntax && !fatal_r) begin
        nonfatal_r <= 1'b1;
        code_r <= `CODE_SYNTAX;
      end else if (run_prev_r == `RUN_DIGIT && ctrl_r.run != `RUN_DIGIT
                   && code_r != `CODE_WDT) begin
        fatal_r <= 1'b0;
        nonfatal_r <= 1'b0;
        code_r <= 8'h00;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      synaddr_r <= `SYNADDR_RESET;
    end else if (err_evt.syntax && !any_err) begin
      synaddr_r <= syntax_addr_bcd;
    end
  end

  // ****************************************
  // polling sequencer
  // ****************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= serial_unit_pkg::POLL_IDLE;
      idx_r <= 5'h0;
      poll_req_r <= 1'b0;
      poll_unit_r <= 5'h0;
    end else begin
      poll_req_r <= 1'b0;
      case (state_r)
        serial_unit_pkg::POLL_IDLE: begin
          if (go) begin
            state_r <= serial_unit_pkg::POLL_ISSUE;
          end else begin
            idx_r <= 5'h0;
          end
        end
        serial_unit_pkg::POLL_ISSUE: begin
          if (go) begin
            poll_req_r <= 1'b1;
            poll_unit_r <= idx_r;
            state_r <= serial_unit_pkg::POLL_WAIT;
          end else begin
            state_r <= serial_unit_pkg::POLL_IDLE;
          end
        end
        serial_unit_pkg::POLL_WAIT: begin
          if (!go) begin
            state_r <= serial_unit_pkg::POLL_IDLE;
          end else if (resp_valid || tmo_exp) begin
            idx_r <= idx_next;
            state_r <= serial_unit_pkg::POLL_ISSUE;
          end
        end
        default: begin
          state_r <= serial_unit_pkg::POLL_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // unit number in bcd
  // ****************************************
  // unit numbers stop at 31, so three compares cover the tens digit
  always_comb begin
    if (idx_r >= 5'd30) begin
      idx_bcd = {4'h3, 4'(idx_r - 5'd30)};
    end else if (idx_r >= 5'd20) begin
      idx_bcd = {4'h2, 4'(idx_r - 5'd20)};
    end else if (idx_r >= 5'd10) begin
      idx_bcd = {4'h1, 4'(idx_r - 5'd10)};
    end else begin
      idx_bcd = {4'h0, 4'(idx_r)};
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      last_unit_r <= 8'h00;
    end else if (ctrl_r.run != `RUN_DIGIT || units == 6'h0) begin
      last_unit_r <= 8'h00;
    end else if (state_r == serial_unit_pkg::POLL_WAIT && go && resp_valid && resp_ok) begin
      last_unit_r <= idx_bcd;
    end
  end

  // ****************************************
  // status word
  // ****************************************
  always_comb begin
    if (any_err) begin
      stat_nxt = {`ERR_FLAG_DIGIT, `STOP_DIGIT_HALT, code_r};
    end else begin
      stat_nxt = {4'h0, (go ? `STOP_DIGIT_RUN : `STOP_DIGIT_HALT), last_unit_r};
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stat_r <= `STAT_RESET;
      running_r <= 1'b0;
    end else begin
      stat_r <= stat_nxt;
      running_r <= go;
    end
  end

  // ****************************************
  // timers and error indicator
  // ****************************************
  interval_timer u_tmo (
    .clk(clk),
    .rst_b(rst_b),
    .start(tmo_start),
    .abort(tmo_abort),
    .load(tmo_load),
    .busy(),
    .expired(tmo_exp)
  );

  // free running, so the blink phase is not tied to the error moment
  interval_timer u_blink (
    .clk(clk),
    .rst_b(rst_b),
    .start(!blink_busy),
    .abort(1'b0),
    .load(BLINK_HALF_CYC),
    .busy(blink_busy),
    .expired(blink_exp)
  );

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      blink_r <= 1'b0;
    end else if (blink_exp) begin
      blink_r <= !blink_r;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      err_led_r <= 1'b0;
    end else if (fatal_r) begin
      err_led_r <= 1'b1;
    end else if (nonfatal_r) begin
      err_led_r <= blink_r;
    end else begin
      err_led_r <= 1'b0;
    end
  end

  assign cpu_rdata = cpu_rdata_r;
  assign poll_req = poll_req_r;
  assign poll_unit = poll_unit_r;
  assign running = running_r;
  assign err_led = err_led_r;

endmodule // serial_unit_control_status

`default_nettype wire

/* dv/su_monitor.sv */
// assertions on the serial unit control and status ports
`timescale 1ns/10ps
`default_nettype none
module su_monitor (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  input wire logic [1:0] cpu_addr,
  input wire logic [15:0] cpu_wdata,
  input wire logic [15:0] cpu_rdata,
  input wire serial_unit_pkg::err_evt_t err_evt,
  input wire logic poll_req,
  input wire logic running,
  input wire logic err_led
);
  logic wdt_r;
  logic [15:0] ctl_r;
  logic [2:0] q_r;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // watchdog clears only by reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) wdt_r <= 1'b0;
    else if (err_evt.wdt) wdt_r <= 1'b1;
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) ctl_r <= 16'h0000;
    else if (cpu_wr && cpu_addr == 2'h0) ctl_r <= cpu_wdata;
  end
  // settle margin covers a poll already in flight
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) q_r <= 3'h0;
    else if (ctl_r[3:0] == 4'h1 && ctl_r[15:8] != 8'h00) q_r <= 3'h0;
    else if (q_r != 3'h7) q_r <= q_r + 3'h1;
  end
  chk_code_legal: assert property (cpu_rd && cpu_addr == 2'h1 |=>
    !cpu_rdata[15] || cpu_rdata[7:0] inside {8'h01, 8'h02, 8'h15}) else $error("bad code");
  chk_flag_digit: assert property (cpu_rd && cpu_addr == 2'h1 |=>
    cpu_rdata[15:12] inside {4'h0, 4'h8}) else $error("bad flag digit");
  chk_stop_digit: assert property (cpu_rd && cpu_addr == 2'h1 |=>
    !cpu_rdata[15] || cpu_rdata[11:8] == 4'h0) else $error("stop digit set");
  chk_run_off: assert property (ctl_r[3:0] != 4'h1 && q_r >= 3'h4 |-> !poll_req)
    else $error("poll while stopped");
  chk_count_zero: assert property (ctl_r[15:8] == 8'h00 && q_r >= 3'h4 |-> !poll_req)
    else $error("poll with zero count");
  chk_wdt_halt: assert property (err_evt.wdt |-> ##3 err_led && !running)
    else $error("watchdog not halted");
  chk_dm_halt: assert property (err_evt.dm_alloc |-> ##3 err_led && !running)
    else $error("alloc error not halted");
  chk_fatal_block: assert property (wdt_r && $past(wdt_r, 2) |-> !poll_req)
    else $error("poll after fatal");
  cov_poll: cover property (poll_req);
  cov_blink: cover property ($fell(err_led) && !running);
  cov_wdt: cover property (err_evt.wdt);
endmodule // su_monitor
bind serial_unit_control_status su_monitor u_mon (.clk, .rst_b, .cpu_wr, .cpu_rd,
  .cpu_addr, .cpu_wdata, .cpu_rdata, .err_evt, .poll_req, .running, .err_led);
`default_nettype wire

/* dv/component_model.sv */
// field component answering the unit's polls
`timescale 1ns/10ps
`default_nettype none
module component_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic poll_req,
  input wire logic mute,
  input wire logic [3:0] dly,
  output logic resp_valid,
  output logic resp_ok
);
  logic [3:0] cnt_r;
  // muted means silent, forcing a timeout
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= 4'h0;
      resp_valid <= 1'b0;
      resp_ok <= 1'b0;
    end else begin
      resp_valid <= 1'b0;
      resp_ok <= ~resp_ok;
      if (poll_req) cnt_r <= dly;
      else if (cnt_r != 4'h0) cnt_r <= cnt_r - 4'h1;
      if (cnt_r == 4'h1 && !poll_req && !mute) begin
        resp_valid <= 1'b1;
        resp_ok <= 1'b1;
      end
    end
  end
endmodule // component_model
`default_nettype wire

/* dv/tb_serial_unit_control_status.sv */
// self-checking bench for the serial unit words
`timescale 1ns/10ps
`default_nettype none
module tb_serial_unit_control_status;
  localparam logic [31:0] TU = 32'h14;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic cpu_wr = 1'b0;
  logic cpu_rd = 1'b0;
  logic mute = 1'b0;
  logic [1:0] cpu_addr = 2'h0;
  logic [15:0] cpu_wdata = 16'h0000;
  logic [15:0] syntax_addr_bcd = 16'h0000;
  serial_unit_pkg::err_evt_t err_evt = 3'h0;
  logic [15:0] cpu_rdata, d;
  logic resp_valid, resp_ok, poll_req, running, err_led;
  logic [4:0] poll_unit, mx;
  int n_errors = 0;
  int total_checks = 0;
  int np, g;
  // control word, units polled, status upper byte
  logic [15:0] rows [5][3] = '{'{16'h0000, 16'h0000, 16'h0000},
    '{16'h0001, 16'h0000, 16'h0000}, '{16'h0300, 16'h0000, 16'h0000},
    '{16'h0301, 16'h0003, 16'h0100}, '{16'h3201, 16'h0020, 16'h0100}};
  logic [3:0] tv [3] = '{4'h0, 4'h1, 4'h9};
  always #5 clk = ~clk;
  serial_unit_control_status #(.TMO_UNIT_CYC(TU), .BLINK_HALF_CYC(32'h4)) dut (.clk, .rst_b,
    .cpu_wr, .cpu_rd, .cpu_addr, .cpu_wdata, .cpu_rdata, .err_evt, .syntax_addr_bcd,
    .resp_valid, .resp_ok, .poll_req, .poll_unit, .running, .err_led);
  component_model far (.clk, .rst_b, .poll_req, .mute, .dly(4'h2), .resp_valid, .resp_ok);
  task final_report();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [1:0] a, input logic [15:0] v);
    cpu_addr = a;
    cpu_wdata = v;
    cpu_wr = 1'b1;
    @(negedge clk);
    cpu_wr = 1'b0;
    @(negedge clk);
  endtask
  task rd(input logic [1:0] a);
    cpu_addr = a;
    cpu_rd = 1'b1;
    @(negedge clk);
    cpu_rd = 1'b0;
    @(negedge clk);
    d = cpu_rdata;
  endtask
  task rdc(input logic [1:0] a, input logic [15:0] e);
    rd(a);
    chk(d, e);
  endtask
  task evt(input logic [2:0] e);
    err_evt = e;
    @(negedge clk);
    err_evt = 3'h0;
    repeat (4) @(negedge clk);
  endtask
  task win(input int n);
    np = 0;
    mx = 5'h0;
    repeat (n) begin
      @(negedge clk);
      if (poll_req === 1'b1) begin
        np++;
        if (poll_unit > mx) mx = poll_unit;
      end
    end
  endtask
  task led();
    np = 0;
    repeat (20) begin
      @(negedge clk);
      if (err_led === 1'b1) np++;
    end
  endtask
  // bounded: a lost poll must not hang the run
  task gap();
    g = 0;
    for (int i = 0; i < 300 && poll_req !== 1'b1; i++) @(negedge clk);
    if (poll_req !== 1'b1) begin
      n_errors++;
      final_report();
    end
    do begin
      @(negedge clk);
      g++;
    end while (poll_req !== 1'b1 && g < 300);
    if (g >= 300) begin
      n_errors++;
      final_report();
    end
  endtask
  task rerun();
    wr(2'h0, 16'h0100);
    wr(2'h0, 16'h0101);
  endtask
  initial begin
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    for (int i = 0; i < 5; i++) begin
      wr(2'h0, rows[i][0]);
      win(300);
      chk(np ? 16'(mx) + 16'h1 : 16'h0, rows[i][1]);
      rd(2'h1);
      chk(rows[i][2] != 16'h0 ? d & 16'hff00 : d, rows[i][2]);
      chk(16'(rows[i][2] == 16'h0 ||
        (d[3:0] <= 4'h9 && d[7:0] < rows[i][0][15:8])), 16'h1);
      wr(2'h0, 16'h0000);
      win(10);
      $display("row %0d done", i);
    end
    mute = 1'b1;
    for (int j = 0; j < 3; j++) begin
      wr(2'h0, {8'h01, tv[j], 4'h1});
      gap();
      gap();
      chk(16'(g >= (tv[j] + 1) * TU && g <= (tv[j] + 1) * TU + 5), 16'h1);
    end
    mute = 1'b0;
    $display("timeout done");
    rerun();
    syntax_addr_bcd = 16'h1234;
    evt(3'h2);
    rdc(2'h1, 16'h8002);
    rdc(2'h2, 16'h1234);
    syntax_addr_bcd = 16'h5678;
    evt(3'h2);
    rdc(2'h2, 16'h1234);
    led();
    chk(16'(np > 0 && np < 20), 16'h1);
    chk(16'(running), 16'h0);
    rerun();
    win(40);
    chk(16'(np > 0), 16'h1);
    evt(3'h1);
    rdc(2'h1, 16'h8015);
    led();
    chk(16'(np), 16'h0014);
    rerun();
    evt(3'h4);
    rdc(2'h1, 16'h8001);
    led();
    chk(16'(np), 16'h0014);
    rerun();
    win(40);
    chk(16'(np), 16'h0);
    wr(2'h1, 16'hffff);
    rdc(2'h1, 16'h8001);
    rdc(2'h3, 16'h0000);
    $display("errors done");
    rst_b = 1'b0;
    @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    rdc(2'h1, 16'h0000);
    rdc(2'h0, 16'h0000);
    final_report();
  end
endmodule // tb_serial_unit_control_status
`default_nettype wire
